// ---- rtl/aics_map.vh ----
`ifndef AICS_MAP_VH
`define AICS_MAP_VH
// Timing figures in their own units and derived cycle counts at 100 MHz
`define AICS_CLK_MHZ        100
`define AICS_POR_US         4000
`define AICS_POR_CYC        (`AICS_POR_US * `AICS_CLK_MHZ)
`define AICS_EOCTEST_US     12
`define AICS_EOCTEST_CYC    (`AICS_EOCTEST_US * `AICS_CLK_MHZ)
// Internal serial clock half period in ref_clk cycles
`define AICS_SCK_HALF_CYC   50
// Frame layout
`define AICS_FRAME_EDGES    24
`define AICS_CFG_BITS       16
`define AICS_RESULT_BITS    24
// Conversion length in ref_clk cycles
`define AICS_CONV_CYC       2000
`endif

// ---- rtl/aics_sync.v ----
`timescale 1ns/1ps
// Two flip-flop synchroniser for a pin level
module aics_sync (
  // Clock and reset
  input  wire ref_clk,
  input  wire rst,
  // Level in and out
  input  wire d,
  output reg  q
);
  reg meta_q;

  // First stage feeds only the second
  always @(posedge ref_clk) begin
    if (rst) begin
      meta_q <= 1'b1;
      q      <= 1'b1;
    end else begin
      meta_q <= d;
      q      <= meta_q;
    end
  end
endmodule // aics_sync

// ---- rtl/aics_core.v ----
`timescale 1ns/1ps
`include "aics_map.vh"
// Contract
// - Clock mode chosen once, when power-on reset cycle ends.
// - Power-on cycle lasts about 4 ms; mode latched at its end.
// - Weak clock-pin pull-up active throughout power-on cycle.
// - Clock and data high while converting; both low at sleep entry.
// - Sleep at least half a clock period, then start transfer.
// - Host input bit captured on each of the first 16 rising edges, first included.
// - Result output updated on each falling clock edge.
// - After 24th rising edge, transfer ends and next conversion starts.
// - Clock pull-up disabled whenever the clock pin is low after power-on cycle, except in status test with chip select high.
// - Chip select rise with clock low, pin floating: leave internal mode at the next chip select fall.
// - Status pulse in sleep drives clock low; early rise re-enables pull-up.
// - Data output reads 1 converting, 0 when done and sleeping.
// - Captured configuration applies only to the following conversion.
module aics_core #(
  parameter POR_CYC   = `AICS_POR_CYC,
  parameter CONV_CYC  = `AICS_CONV_CYC,
  parameter TEST_CYC  = `AICS_EOCTEST_CYC,
  parameter HALF_CYC  = `AICS_SCK_HALF_CYC
) (
  // Clock and reset
  input  wire        ref_clk,
  input  wire        rst,
  // Serial pins
  input  wire        cs_n,
  input  wire        sdi,
  input  wire        sck_i,
  output reg         sck_o,
  output wire        sck_oe_n,
  output reg         pullup_en,
  output reg         sdo,
  // Converter side
  input  wire [23:0] result,
  output reg  [15:0] cfg,
  output reg         conv_start,
  output reg         int_mode,
  output reg         por_done
);
  localparam S_CONV  = 4'b0001;
  localparam S_SLEEP = 4'b0010;
  localparam S_XFER  = 4'b0100;
  localparam S_TEST  = 4'b1000;

  wire        cs_s;
  wire        sck_s;
  reg  [3:0]  state_q;
  reg  [31:0] cnt_q;
  reg  [31:0] por_q;
  reg  [4:0]  edge_q;
  reg  [23:0] shift_q;
  reg  [15:0] in_q;
  reg         cs_d1_q;
  reg         lost_q;

  wire [2:0]  pin_raw;
  wire [2:0]  pin_s;
  wire        sdi_s;

  // Counter reached the last cycle of a span
  function at_end;
    input [31:0] count;
    input [31:0] span;
    begin
      at_end = (count == span - 32'h1);
    end
  endfunction

  // Pin synchronisers: chip select, clock pin, host data
  assign pin_raw = {sdi, sck_i, cs_n};
  genvar gi;
  generate
    for (gi = 0; gi < 3; gi = gi + 1) begin : g_sync
      aics_sync i_sync (
        .ref_clk (ref_clk),
        .rst     (rst),
        .d       (pin_raw[gi]),
        .q       (pin_s[gi])
      );
    end
  endgenerate
  assign cs_s  = pin_s[0];
  assign sck_s = pin_s[1];
  assign sdi_s = pin_s[2];

  // Device drives clock only in internal mode after power-on
  assign sck_oe_n = ~(int_mode & por_done);

  // Power-on cycle; mode latched once at its end
  always @(posedge ref_clk) begin
    if (rst) begin
      por_q    <= 32'h0;
      por_done <= 1'b0;
      int_mode <= 1'b0;
    end else if (!por_done) begin
      if (at_end(por_q, POR_CYC)) begin
        por_done <= 1'b1;
        int_mode <= sck_s;
      end else begin
        por_q <= por_q + 32'h1;
      end
    end else if (lost_q && cs_d1_q && !cs_s) begin
      int_mode <= 1'b0;
    end
  end

  // Pull-up control
  always @(posedge ref_clk) begin
    if (rst) begin
      pullup_en <= 1'b1;
      lost_q    <= 1'b0;
      cs_d1_q   <= 1'b1;
    end else begin
      cs_d1_q <= cs_s;
      if (!por_done)
        pullup_en <= 1'b1;
      else if (state_q == S_TEST && cs_s)
        pullup_en <= 1'b1;
      else if (!sck_s)
        pullup_en <= 1'b0;
      else
        pullup_en <= 1'b1;
      // Chip select rose while clock driven low and pull-up off
      if (cs_s && !cs_d1_q && !sck_o && !pullup_en)
        lost_q <= 1'b1;
      else if (sck_s && pullup_en)
        lost_q <= 1'b0;
    end
  end

  // Sequencer
  always @(posedge ref_clk) begin
    if (rst) begin
      state_q    <= S_CONV;
      cnt_q      <= 32'h0;
      edge_q     <= 5'h0;
      sck_o      <= 1'b1;
      sdo        <= 1'b1;
      shift_q    <= 24'h0;
      in_q       <= 16'h0;
      cfg        <= 16'h0;
      conv_start <= 1'b0;
    end else begin
      conv_start <= 1'b0;
      case (state_q)
        S_CONV: begin
          sck_o <= 1'b1;
          sdo   <= 1'b1;
          if (!por_done || !int_mode) begin
            cnt_q <= 32'h0;
          end else if (at_end(cnt_q, CONV_CYC)) begin
            cnt_q   <= 32'h0;
            sck_o   <= 1'b0;
            sdo     <= 1'b0;
            shift_q <= result;
            state_q <= S_SLEEP;
          end else begin
            cnt_q <= cnt_q + 32'h1;
          end
        end
        S_SLEEP: begin
          if (cs_s && !cs_d1_q) begin
            cnt_q   <= 32'h0;
            state_q <= S_TEST;
          end else if (at_end(cnt_q, HALF_CYC)) begin
            cnt_q   <= 32'h0;
            edge_q  <= 5'h0;
            sdo     <= shift_q[23];
            shift_q <= {shift_q[22:0], 1'b0};
            state_q <= S_XFER;
          end else begin
            cnt_q <= cnt_q + 32'h1;
          end
        end
        S_TEST: begin
          sck_o <= 1'b0;
          if (cs_s) begin
            cnt_q <= 32'h0;
          end else if (at_end(cnt_q, TEST_CYC)) begin
            cnt_q   <= 32'h0;
            state_q <= S_SLEEP;
          end else begin
            cnt_q <= cnt_q + 32'h1;
          end
        end
        S_XFER: begin
          if (at_end(cnt_q, HALF_CYC)) begin
            cnt_q <= 32'h0;
            if (!sck_o) begin
              // Rising edge: sample host bit
              sck_o  <= 1'b1;
              edge_q <= edge_q + 5'h1;
              if (edge_q < `AICS_CFG_BITS)
                in_q <= {in_q[14:0], sdi_s};
              if (edge_q == `AICS_FRAME_EDGES - 1) begin
                sdo        <= 1'b1;
                cfg        <= in_q;
                conv_start <= 1'b1;
                state_q    <= S_CONV;
              end
            end else begin
              // Falling edge: next result bit
              sck_o   <= 1'b0;
              sdo     <= shift_q[23];
              shift_q <= {shift_q[22:0], 1'b0};
            end
          end else begin
            cnt_q <= cnt_q + 32'h1;
          end
        end
        default: state_q <= S_CONV;
      endcase
    end
  end
endmodule // aics_core

// ---- testbench/aics_core_assertions.sv ----
`timescale 1ns/1ps
// Pin checks on the sequencer
module aics_chk (
  // Clock and reset
  input wire        ref_clk,
  input wire        rst,
  // Pins and status
  input wire        cs_n,
  input wire        sck_i,
  input wire        sck_o,
  input wire        pullup_en,
  input wire        sdo,
  input wire [15:0] cfg,
  input wire        conv_start,
  input wire        int_mode,
  input wire        por_done
);
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (rst);
  // Mode choice and pull-up
  AST_POR_PULL: assert property (!por_done |-> pullup_en) else $error("pull");
  AST_MODE_HOLD: assert property ($past(por_done) |-> $stable(int_mode))
    else $error("mode");
  AST_PULL_OFF: assert property ((por_done && !cs_n && !sck_i)[*6] |-> !pullup_en)
    else $error("pull");
  // Frame timing
  AST_EOC_PAIR: assert property ($fell(sdo) |-> !sck_o) else $error("eoc");
  AST_HALF: assert property ($fell(sck_o) |-> (!sck_o)[*4]) else $error("half");
  AST_SDO_FALL: assert property (int_mode && sck_o && $past(sck_o) |-> $stable(sdo))
    else $error("sdo");
  AST_CONV_HIGH: assert property (conv_start |=> (sck_o && sdo)[*8])
    else $error("conv");
  AST_CFG_NEXT: assert property ($changed(cfg) |-> conv_start || $past(conv_start))
    else $error("cfg");
endmodule // aics_chk
bind aics_core aics_chk i_aics_chk (.ref_clk, .rst, .cs_n, .sck_i, .sck_o, .pullup_en, .sdo,
  .cfg, .conv_start, .int_mode, .por_done);

// ---- testbench/aics_host.sv ----
`timescale 1ns/1ps
// Host: chip select low, config in, result out
module aics_host (
  // Clock
  input  wire        ref_clk,
  // Device pins
  input  wire        sck_o,
  input  wire        sck_oe_n,
  input  wire        pullup_en,
  input  wire        sdo,
  output wire        sck_i,
  output wire        sdi,
  output wire        cs_n,
  // Bench side
  input  wire        ext_low,
  input  wire [15:0] tx,
  output reg  [23:0] rx_q,
  output reg         got_q
);
  reg       sck_q = 1'b1;
  reg       sdo_q = 1'b1;
  reg       pin_q = 1'b1;
  reg [4:0] n_q   = 5'h00;
  // Select held low, pin resolved from all drivers
  assign cs_n = 1'b0;
  assign sck_i = !sck_oe_n ? sck_o : ext_low ? 1'b0 : pullup_en ? 1'b1 : ~pin_q;
  // Bits change only after a rising edge
  assign sdi = (n_q < 5'h10) ? tx[5'h0f - n_q] : 1'b1;
  // Result bit is the level that stood at the clock rise
  always @(posedge ref_clk) begin
    sck_q <= sck_o;
    sdo_q <= sdo;
    pin_q <= sck_i;
    got_q <= 1'b0;
    if (!sck_oe_n && sck_o && !sck_q) begin
      rx_q  <= {rx_q[22:0], sdo_q};
      n_q   <= (n_q == 5'h17) ? 5'h00 : n_q + 5'h01;
      got_q <= (n_q == 5'h17);
    end
  end
endmodule // aics_host

// ---- testbench/test_adc_internal_sck_continuous_io.sv ----
`timescale 1ns/1ps
// Bench for the continuous internal-clock sequencer
module test_adc_internal_sck_continuous_io;
  reg         ref_clk, rst, ext_low;
  reg  [23:0] result;
  reg  [15:0] tx;
  wire        cs_n, sdi, sck_i, sck_o, sck_oe_n, pullup_en, sdo, conv_start, int_mode, por_done, got;
  wire [23:0] rx;
  wire [15:0] cfg;
  integer     n_mismatch, num_checks, cyc, all_cyc, n_conv;
  aics_core #(.POR_CYC(100), .CONV_CYC(50), .TEST_CYC(20), .HALF_CYC(4)) i_aics_core (.ref_clk,
    .rst, .cs_n, .sdi, .sck_i, .sck_o, .sck_oe_n, .pullup_en, .sdo, .result, .cfg, .conv_start,
    .int_mode, .por_done);
  aics_host i_aics_host (.ref_clk, .sck_o, .sck_oe_n, .pullup_en, .sdo, .sck_i, .sdi, .cs_n,
    .ext_low, .tx, .rx_q(rx), .got_q(got));
  // Clock and hang guard
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk) begin
    all_cyc = all_cyc + 1;
    if (all_cyc == 3000) begin
      n_mismatch = n_mismatch + 1;
      close_out;
    end
  end
  // Count conversion start pulses
  always @(posedge ref_clk) begin
    if (conv_start === 1'b1)
      n_conv = n_conv + 1;
  end
  task chk(input [23:0] exp, input [23:0] seen, input [8*8:1] what);
    begin
      num_checks = num_checks + 1;
      if (seen !== exp) begin
        n_mismatch = n_mismatch + 1;
        $display("BAD %0s exp %h got %h", what, exp, seen);
      end
    end
  endtask
  task t_reset(input e);
    begin
      @(posedge ref_clk);
      #1 rst = 1'b1;
      ext_low = e;
      repeat (20) @(posedge ref_clk);
      #1 rst = 1'b0;
    end
  endtask
  // Power-on cycle and mode pick
  task t_por;
    begin
      t_reset(1'b0);
      chk(1'b1, pullup_en, "pullup");
      cyc = 0;
      while (por_done !== 1'b1) begin
        @(posedge ref_clk);
        #1 cyc = cyc + 1;
      end
      chk(24'd100, cyc, "porlen");
      #20 chk(1'b1, int_mode, "mode");
      $display("por done");
    end
  endtask
  // Two frames back to back
  task t_frames;
    begin
      wait (sdo === 1'b0);
      #1 chk(1'b0, sck_o, "sleep");
      @(posedge got);
      #1 chk(24'ha5c3e1, rx, "rx1");
      result = 24'h3c5a96;
      @(posedge ref_clk);
      #2 chk(2'b11, {sck_o, sdo}, "conv");
      chk(16'h9a6c, cfg, "cfg");
      @(posedge got);
      #1 chk(24'h3c5a96, rx, "rx2");
      chk(24'd2, n_conv, "convs");
      $display("frames done");
    end
  endtask
  // Clock pin low at power-on end
  task t_ext;
    begin
      t_reset(1'b1);
      wait (por_done === 1'b1);
      repeat (2) @(posedge ref_clk);
      #1 ext_low = 1'b0;
      repeat (60) @(posedge ref_clk);
      #1 chk(2'b01, {int_mode, sck_oe_n}, "ext");
      $display("ext done");
    end
  endtask
  task close_out;
    begin
      $display("checks %0d mismatches %0d", num_checks, n_mismatch);
      if (n_mismatch == 0 && num_checks > 0)
        $display("TEST PASSED");
      else
        $display("TEST FAILED");
      $finish;
    end
  endtask
  // Main sequence
  initial begin
    n_mismatch = 0;
    num_checks = 0;
    all_cyc = 0;
    n_conv = 0;
    rst = 1'b1;
    ext_low = 1'b0;
    result = 24'ha5c3e1;
    tx = 16'h9a6c;
    t_por;
    t_frames;
    t_ext;
    close_out;
  end
endmodule // test_adc_internal_sck_continuous_io
